// [inc/suc_pkg.sv]
// Constants and types for the sync and update control register bank
package suc_pkg;
  localparam int          ADDR_W          = 10;
  localparam int          DATA_W          = 8;
  localparam logic [9:0]  ADDR_SYS_CTRL   = 10'h230;
  localparam logic [9:0]  ADDR_UPDATE     = 10'h232;
  localparam int          BIT_SYNC_PD     = 2;
  localparam int          BIT_DIST_REF_PD = 1;
  localparam int          BIT_SOFT_SYNC   = 0;
  localparam int          BIT_UPDATE      = 0;
  localparam logic [2:0]  SYS_CTRL_RESET  = 3'h0;
  localparam int          SYS_CTRL_W      = 3;
  localparam logic        PIN_IDLE        = 1'b1;
  localparam logic [7:0]  READ_ZERO       = 8'h00;
endpackage

// [logic/suc_sync_in.sv]
// Two-stage synchroniser for the external active-low sync pin
`timescale 1ns/1ps
module suc_sync_in
  import suc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Pin and synchronised level
  input  wire logic pin_n,
  output logic      level_n
);
  logic stage1;
  logic next_stage1;
  logic next_level_n;

  // Idle level of the pin is high, so reset to high
  always_comb
  begin
    next_stage1  = pin_n;
    next_level_n = stage1;
  end

  // Both stages reset to idle so no false request follows reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      stage1  <= PIN_IDLE;
      level_n <= PIN_IDLE;
    end
    else
    begin
      stage1  <= next_stage1;
      level_n <= next_level_n;
    end
  end
endmodule

// [logic/suc_top.sv]
// Sync power-down and update-all control register bank
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module suc_top
  import suc_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rstn,
  // Register port
  input  wire logic [suc_pkg::ADDR_W-1:0] addr,
  input  wire logic [suc_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic      [suc_pkg::DATA_W-1:0] rdata,
  // External sync pin, active low
  input  wire logic                       sync_pin_n,
  // Controls to the distribution logic
  output logic                            sync_pd,
  output logic                            dist_ref_pd,
  output logic                            sync_hold,
  output logic                            sync_trigger,
  output logic                            update_pulse
);
  import suc_pkg::*;

  // Field positions, widths and addresses all come from the package

  // Control word: sync power-down, reference power-down, soft sync
  logic [SYS_CTRL_W-1:0] sys_ctrl;
  logic [SYS_CTRL_W-1:0] next_sys_ctrl;
  // One-cycle update command
  logic                  update_bit;
  logic                  next_update_bit;
  // Read data for the cycle after a read strobe
  logic [DATA_W-1:0]     next_rdata;
  // Decoded register strobes
  logic                  wr_ctrl;
  logic                  wr_update;
  logic                  rd_ctrl;
  // Sync request, from the pin and from the soft bit
  logic                  pin_level_n;
  logic                  pin_req;
  logic                  soft_req;
  logic                  sync_req;
  // Request history and its registered forms
  logic                  req_prev;
  logic                  next_req_prev;
  logic                  next_sync_hold;
  logic                  next_sync_trigger;
  // Registered power-down levels
  logic                  next_sync_pd;
  logic                  next_dist_ref_pd;
  // Registered update command
  logic                  next_update_pulse;

  // Pin crosses into the register clock before any logic reads it
  suc_sync_in u_sync_in
  (
    .clk     (clk),
    .rstn    (rstn),
    .pin_n   (sync_pin_n),
    .level_n (pin_level_n)
  );

  // Address match used by both the write and read paths
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  // Control field of a write word; bits above it are ignored
  function automatic logic [SYS_CTRL_W-1:0] ctrl_field
  (
    input logic [DATA_W-1:0] w
  );
    ctrl_field = w[SYS_CTRL_W-1:0];
  endfunction

  // Read word of the control register; unused bits read as zero
  function automatic logic [DATA_W-1:0] ctrl_word
  (
    input logic [SYS_CTRL_W-1:0] c
  );
    ctrl_word = {{(DATA_W-SYS_CTRL_W){1'b0}}, c};
  endfunction

  // Release of a request: asserted last cycle, dropped now
  function automatic logic released
  (
    input logic prev,
    input logic cur
  );
    released = prev && !cur;
  endfunction

  // Strobe decode; the master never raises wr and rd together
  always_comb
  begin
    wr_ctrl   = wr && hit(addr, ADDR_SYS_CTRL);
    wr_update = wr && hit(addr, ADDR_UPDATE);
    rd_ctrl   = rd && hit(addr, ADDR_SYS_CTRL);
  end

  // Control word takes the low bits of a write; others are dropped
  always_comb
  begin
    next_sys_ctrl = sys_ctrl;
    if (wr_ctrl)
    begin
      next_sys_ctrl = ctrl_field(wdata);
    end
  end

  // Power-up default has sync and reference running, soft sync off
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sys_ctrl <= SYS_CTRL_RESET;
    end
    else
    begin
      sys_ctrl <= next_sys_ctrl;
    end
  end

  // Update bit clears on the next cycle, so software never writes 0
  always_comb
  begin
    next_update_bit = 1'b0;
    if (wr_update)
    begin
      next_update_bit = wdata[BIT_UPDATE];
    end
  end

  // Update command register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      update_bit <= 1'b0;
    end
    else
    begin
      update_bit <= next_update_bit;
    end
  end

  // Only the control word reads back; the update bit reads as zero
  always_comb
  begin
    next_rdata = READ_ZERO;
    if (rd_ctrl)
    begin
      next_rdata = ctrl_word(sys_ctrl);
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      rdata <= READ_ZERO;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Pin is active low and the soft bit active high; both mean hold
  always_comb
  begin
    pin_req  = !pin_level_n;
    soft_req = sys_ctrl[BIT_SOFT_SYNC];
    sync_req = pin_req || soft_req;
    // A powered-down sync block ignores every request
    if (sys_ctrl[BIT_SYNC_PD])
    begin
      sync_req = 1'b0;
    end
  end

  // History of the request feeds the release detector
  always_comb
  begin
    next_req_prev = sync_req;
  end

  // History resets to idle so that no false release follows reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      req_prev <= 1'b0;
    end
    else
    begin
      req_prev <= next_req_prev;
    end
  end

  // Channels stay static for as long as the request stands
  always_comb
  begin
    next_sync_hold = sync_req;
  end

  // Hold level to the distribution logic
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync_hold <= 1'b0;
    end
    else
    begin
      sync_hold <= next_sync_hold;
    end
  end

  // Power-down of the sync block while held must not fire a sync
  always_comb
  begin
    next_sync_trigger = 1'b0;
    // Only a live sync block may fire on a release
    if (!sys_ctrl[BIT_SYNC_PD])
    begin
      next_sync_trigger = released(req_prev, sync_req);
    end
  end

  // Trigger is a one-cycle pulse, in the cycle in which hold falls
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync_trigger <= 1'b0;
    end
    else
    begin
      sync_trigger <= next_sync_trigger;
    end
  end

  // Sync power-down level goes straight to the distribution logic
  always_comb
  begin
    next_sync_pd = sys_ctrl[BIT_SYNC_PD];
  end

  // Sync power-down output, one cycle behind the control word
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sync_pd <= 1'b0;
    end
    else
    begin
      sync_pd <= next_sync_pd;
    end
  end

  // Reference power-down level goes straight to the distribution
  always_comb
  begin
    next_dist_ref_pd = sys_ctrl[BIT_DIST_REF_PD];
  end

  // Reference power-down output, one cycle behind the control word
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      dist_ref_pd <= 1'b0;
    end
    else
    begin
      dist_ref_pd <= next_dist_ref_pd;
    end
  end

  // All buffered values move to the active side on this pulse
  always_comb
  begin
    next_update_pulse = update_bit;
  end

  // Update pulse; two writes in a row give two transfers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      update_pulse <= 1'b0;
    end
    else
    begin
      update_pulse <= next_update_pulse;
    end
  end
endmodule

// [tb/suc_top_chk.sv]
// Port assertions for the sync and update control bank
`timescale 1ns/1ps
module suc_top_chk
  import suc_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // Register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  // External sync pin
  input wire logic              sync_pin_n,
  // Controls
  input wire logic              sync_pd,
  input wire logic              dist_ref_pd,
  input wire logic              sync_hold,
  input wire logic              sync_trigger,
  input wire logic              update_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Decoded writes, kept as plain wires so properties stay short
  wire wc = wr && addr == ADDR_SYS_CTRL;
  wire wu = wr && addr == ADDR_UPDATE && wdata[BIT_UPDATE];
  property p_spd; wc |-> ##2 sync_pd == $past(wdata[2], 2); endproperty
  a_spd: assert property (p_spd) else $error("bad sync_pd");
  property p_drp; wc |-> ##2 dist_ref_pd == $past(wdata[1], 2); endproperty
  a_drp: assert property (p_drp) else $error("bad dist_ref_pd");
  property p_hld; wc && wdata[0] && !wdata[2] |-> ##2 sync_hold; endproperty
  a_hld: assert property (p_hld) else $error("no hold");
  property p_trg; $fell(sync_hold) && !sync_pd |-> sync_trigger; endproperty
  a_trg: assert property (p_trg) else $error("no trigger");
  property p_upd; wu |-> ##2 update_pulse; endproperty
  a_upd: assert property (p_upd) else $error("bad update");
  property p_upq; update_pulse |-> $past(wu, 2); endproperty
  a_upq: assert property (p_upq) else $error("stray update");
  property p_ucl; update_pulse && !$past(wu) |=> !update_pulse; endproperty
  a_ucl: assert property (p_ucl) else $error("update stuck");
  property p_pin; !sync_pin_n |-> ##3 sync_hold == !sync_pd; endproperty
  a_pin: assert property (p_pin) else $error("pin not mirrored");
  property p_urd; rd && addr == ADDR_UPDATE |=> rdata == 8'h00; endproperty
  a_urd: assert property (p_urd) else $error("update reads set");
  property p_pd; sync_pd |-> !sync_hold && !sync_trigger; endproperty
  a_pd: assert property (p_pd) else $error("sync while down");
  property p_rz; !rd |=> rdata == 8'h00; endproperty
  a_rz: assert property (p_rz) else $error("stray rdata");
endmodule
bind suc_top suc_top_chk u_chk (.*);

// [tb/test_suc_top.sv]
// Self-checking bench for the sync and update control bank
`timescale 1ns/1ps
module test_suc_top;
  import suc_pkg::*;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0, rd_d = 0, sync_pin_n = 1;
  logic [9:0] addr = '0;
  logic [7:0] wdata = '0, rdata, d;
  logic       sync_pd, dist_ref_pd, sync_hold, sync_trigger, update_pulse;
  logic [7:0] q[$];
  int         error_cnt = 0, samples_checked = 0, seed = 76490, i;
  wire  [2:0] sig = {sync_hold, sync_trigger, update_pulse};
  always #2.5 clk = ~clk;
  suc_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sync_pin_n(sync_pin_n),
    .sync_pd(sync_pd), .dist_ref_pd(dist_ref_pd), .sync_hold(sync_hold),
    .sync_trigger(sync_trigger), .update_pulse(update_pulse));
  task chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask
  task end_of_test;
    if (error_cnt == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Strobes stay up between calls, so accesses run back to back
  task put(input logic [9:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task get(input logic [9:0] a, input logic [7:0] e);
    q.push_back(e);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
  endtask
  // Sampled at the falling edge, where registered outputs have settled
  task wt(input int k);
    int n;
    wr <= 1'b0;
    rd <= 1'b0;
    for (n = 0; n < 20 && sig[k] !== 1'b1; n++)
      @(negedge clk);
    chk({7'h00, sig[k]}, 8'h01);
    if (n == 20)
      end_of_test;
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    rd_d <= rd;
    if (rd_d)
      chk(rdata, q.pop_front());
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    get(ADDR_SYS_CTRL, READ_ZERO);
    for (i = 0; i < 20; i++)
    begin
      d = $random(seed);
      put(ADDR_SYS_CTRL, d);
      put({1'b0, d, 1'b1}, ~d);
      put(ADDR_UPDATE, d & 8'hfe);
      get(ADDR_SYS_CTRL, {5'h00, d[2:0]});
      get({1'b0, d, 1'b1}, READ_ZERO);
      get(ADDR_UPDATE, READ_ZERO);
    end
    put(ADDR_SYS_CTRL, 8'h00);
    put(ADDR_UPDATE, 8'h01);
    wt(0);
    put(ADDR_SYS_CTRL, 8'h01);
    wt(2);
    put(ADDR_SYS_CTRL, 8'h00);
    wt(1);
    sync_pin_n <= 1'b0;
    wt(2);
    sync_pin_n <= 1'b1;
    wt(1);
    put(ADDR_SYS_CTRL, 8'h04);
    wr <= 1'b0;
    sync_pin_n <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({7'h00, sync_hold}, 8'h00);
    chk({6'h00, sync_pd, dist_ref_pd}, 8'h02);
    @(posedge clk);
    put(ADDR_SYS_CTRL, 8'h02);
    wt(2);
    @(negedge clk);
    chk({6'h00, sync_pd, dist_ref_pd}, 8'h01);
    end_of_test;
  end
endmodule
